/* hdl/ptu_pkg.sv */
// Shared constants and types of the page translation unit
package ptu_pkg;
    // Page entry fields
    localparam int BIT_PRESENT  = 0;
    localparam int BIT_WRITE    = 1;
    localparam int BIT_USER     = 2;
    localparam int BIT_ACCESSED = 5;
    localparam int BIT_DIRTY    = 6;
    localparam int PAGE_BITS    = 12;
    localparam int DIR_LO       = 22;
    localparam int TBL_LO       = 12;
    localparam int IDX_BITS     = 10;
    // Translation cache shape
    localparam int TLB_WAYS     = 4;
    localparam int TLB_ENTRIES  = 32;
    // Privilege level treated as user
    localparam logic [1:0] USER_CPL = 2'h3;
    // Exception vector of every page fault
    localparam logic [7:0] VEC_PAGE_FAULT = 8'h0E;
    // Error code bit positions
    localparam int ERR_PROT  = 0;
    localparam int ERR_WRITE = 1;
    localparam int ERR_USER  = 2;
    // Register byte offsets
    localparam logic [11:0] OFS_DIR_BASE   = 12'h000;
    localparam logic [11:0] OFS_FAULT_ADDR = 12'h004;
    localparam logic [11:0] OFS_ERR_CODE   = 12'h008;
    localparam logic [11:0] OFS_FAULT_IP   = 12'h00C;
    localparam logic [11:0] OFS_STATUS     = 12'h010;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Walk sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOOK, ST_PDE_RD, ST_PDE_WR, ST_PTE_RD, ST_PTE_WR
    } ptu_state_t;
endpackage : ptu_pkg

/* hdl/ptu_top.sv */
// Page translation unit: translation cache, table walker, protection, APB registers
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ptu_top #(
    parameter int NUM_SETS = 8                   // Sets of four ways
) (
    input  wire logic        i_clk_sys,          // System clock
    input  wire logic        i_rst,              // Synchronous reset, high
    input  wire logic        i_ce,               // Clock enable, freezes all state
    input  wire logic        i_psel,             // APB select
    input  wire logic        i_penable,          // APB enable
    input  wire logic        i_pwrite,           // APB write
    input  wire logic [11:0] i_paddr,            // APB byte address
    input  wire logic [31:0] i_pwdata,           // APB write data
    output logic      [31:0] o_prdata,           // APB read data
    output logic             o_pready,           // APB ready
    output logic             o_pslverr,          // APB error on unmapped address
    input  wire logic        i_req_valid,        // Linear access request
    output logic             o_req_ready,        // Request taken
    input  wire logic [31:0] i_lin_addr,         // Linear address
    input  wire logic        i_req_write,        // 1 write, 0 read
    input  wire logic [1:0]  i_cpl,              // Current privilege level
    input  wire logic        i_desc_access,      // Descriptor-table access
    input  wire logic [47:0] i_instr_ptr,        // Pointer of requesting instruction
    output logic             o_done,             // Translation done, pulse
    output logic      [31:0] o_phys_addr,        // Physical address
    output logic             o_fault,            // Page fault, pulse
    output logic      [7:0]  o_fault_vec,        // Exception vector
    output logic      [15:0] o_err_code,         // Error code to push
    output logic      [47:0] o_fault_ret,        // fault_return_pointer
    input  wire logic        i_task_sw,          // Task switch reload strobe
    input  wire logic [31:0] i_task_dir_base,    // New directory base
    output logic             o_mem_req,          // Table bus request
    output logic             o_mem_we,           // Table bus write
    output logic             o_mem_lock,         // Bus lock
    output logic      [31:0] o_mem_addr,         // Table bus address
    output logic      [31:0] o_mem_wdata,        // Table bus write data
    input  wire logic        i_mem_ack,          // Bus cycle complete
    input  wire logic [31:0] i_mem_rdata         // Bus read data
);
    import ptu_pkg::*;

    localparam int SW = $clog2(NUM_SETS);
    localparam int TW = 20 - SW;

    initial begin
        if (NUM_SETS < 2 || (1 << SW) != NUM_SETS || NUM_SETS * TLB_WAYS != TLB_ENTRIES)
            $error("ptu_top: NUM_SETS must make a four-way 32-entry cache");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Numerically smaller rights pair is the more restrictive one
    function automatic logic [1:0] min_rights(input logic [1:0] a, input logic [1:0] b);
        min_rights = (a < b) ? a : b;
    endfunction : min_rights

    // Rights pair is {user, write}; supervisors pass unchecked
    function automatic logic rights_ok(input logic [1:0] r, input logic usr,
                                       input logic wr);
        rights_ok = !usr || (r[1] && (r[0] || !wr));
    endfunction : rights_ok

    // Tree pseudo-LRU victim
    function automatic logic [1:0] plru_victim(input logic [2:0] t);
        plru_victim = t[0] ? {1'b1, t[2]} : {1'b0, t[1]};
    endfunction : plru_victim

    // Point the tree away from the way just used
    function automatic logic [2:0] plru_touch(input logic [2:0] t, input logic [1:0] w);
        logic [2:0] n;
        n = t;
        n[0] = !w[1];
        if (w[1])
            n[2] = !w[0];
        else
            n[1] = !w[0];
        plru_touch = n;
    endfunction : plru_touch

    ////////////////////////////////////////////////////////////////////////////
    // State

    ptu_state_t  state_q, state_d;
    logic [31:0] lin_q;
    logic        wr_q, usr_q, desc_q;
    logic [47:0] ip_q;
    logic [31:0] pde_q;
    logic [31:0] dir_base_q;
    logic        stale_q;
    logic        flush;

    logic [TW-1:0] tag_q    [NUM_SETS][TLB_WAYS];
    logic [19:0]   frame_q  [NUM_SETS][TLB_WAYS];
    logic [1:0]    rights_q [NUM_SETS][TLB_WAYS];
    logic          dirty_q  [NUM_SETS][TLB_WAYS];
    logic          valid_q  [NUM_SETS][TLB_WAYS];
    logic [2:0]    plru_q   [NUM_SETS];

    logic [SW-1:0] set_idx;
    logic [TW-1:0] tag_in;
    logic          hit;
    logic [1:0]    hit_way, fill_way;
    logic [1:0]    eff_rights;
    logic          fire_done, fire_fault, fault_prot, fill;
    logic [31:0]   phys_d;
    logic          mem_load;
    logic [31:0]   mem_addr_d, mem_wdata_d;
    logic          mem_we_d;
    logic [31:0]   pte_w;

    // Upper 20 bits split into set index and tag
    assign set_idx = lin_q[PAGE_BITS +: SW];
    assign tag_in  = lin_q[31 -: TW];

    ////////////////////////////////////////////////////////////////////////////
    // Cache lookup across all ways of the set, plus victim choice

    always_comb begin
        hit      = 1'b0;
        hit_way  = 2'h0;
        fill_way = plru_victim(plru_q[set_idx]);
        for (int w = TLB_WAYS - 1; w >= 0; w--) begin
            if (valid_q[set_idx][w] && tag_q[set_idx][w] == tag_in) begin
                hit     = 1'b1;
                hit_way = w[1:0];
            end
            if (!valid_q[set_idx][w])
                fill_way = w[1:0];
        end
        // Refill a hit way in place so one tag never sits in two ways
        if (hit)
            fill_way = hit_way;
    end

    // Directory rights cover the table, table rights the one page
    assign eff_rights = min_rights({pde_q[BIT_USER], pde_q[BIT_WRITE]},
                                   {i_mem_rdata[BIT_USER], i_mem_rdata[BIT_WRITE]});

    // Table entry at the fill edge; the data flop is only loaded at that same edge
    assign pte_w = (state_q == ST_PTE_RD) ? i_mem_rdata : o_mem_wdata;

    ////////////////////////////////////////////////////////////////////////////
    // Walk sequencer, next state and actions

    always_comb begin
        state_d     = state_q;
        fire_done   = 1'b0;
        fire_fault  = 1'b0;
        fault_prot  = 1'b0;
        fill        = 1'b0;
        phys_d      = {frame_q[set_idx][hit_way], lin_q[PAGE_BITS-1:0]};
        mem_load    = 1'b0;
        mem_we_d    = 1'b0;
        mem_wdata_d = i_mem_rdata;
        mem_addr_d  = {dir_base_q[31:PAGE_BITS], lin_q[31:DIR_LO], 2'h0};
        case (state_q)
            ST_IDLE: begin
                if (i_req_valid)
                    state_d = ST_LOOK;
            end
            ST_LOOK: begin
                mem_load = 1'b1;
                if (!hit) begin
                    state_d = ST_PDE_RD;
                end else if (!rights_ok(rights_q[set_idx][hit_way], usr_q, wr_q)) begin
                    fire_fault = 1'b1;
                    fault_prot = 1'b1;
                    state_d    = ST_IDLE;
                end else if (wr_q && !dirty_q[set_idx][hit_way]) begin
                    state_d = ST_PDE_RD; // First write must still mark the page dirty
                end else begin
                    fire_done = 1'b1;
                    state_d   = ST_IDLE;
                end
            end
            ST_PDE_RD: begin
                if (i_mem_ack) begin
                    mem_load = 1'b1;
                    if (!i_mem_rdata[BIT_PRESENT]) begin
                        fire_fault = 1'b1;
                        state_d    = ST_IDLE;
                    end else if (!i_mem_rdata[BIT_ACCESSED]) begin
                        mem_we_d    = 1'b1;
                        mem_addr_d  = o_mem_addr;
                        mem_wdata_d = i_mem_rdata | (32'h1 << BIT_ACCESSED);
                        state_d     = ST_PDE_WR;
                    end else begin
                        mem_addr_d = {i_mem_rdata[31:PAGE_BITS], lin_q[DIR_LO-1:TBL_LO], 2'h0};
                        state_d    = ST_PTE_RD;
                    end
                end
            end
            ST_PDE_WR: begin
                if (i_mem_ack) begin
                    mem_load   = 1'b1;
                    mem_addr_d = {pde_q[31:PAGE_BITS], lin_q[DIR_LO-1:TBL_LO], 2'h0};
                    state_d    = ST_PTE_RD;
                end
            end
            ST_PTE_RD: begin
                phys_d = {i_mem_rdata[31:PAGE_BITS], lin_q[PAGE_BITS-1:0]};
                if (i_mem_ack) begin
                    mem_load = 1'b1;
                    if (!i_mem_rdata[BIT_PRESENT]) begin
                        fire_fault = 1'b1;
                        state_d    = ST_IDLE;
                    end else if (!rights_ok(eff_rights, usr_q, wr_q)) begin
                        fire_fault = 1'b1;
                        fault_prot = 1'b1;
                        state_d    = ST_IDLE;
                    end else if (!i_mem_rdata[BIT_ACCESSED] ||
                                 (wr_q && !i_mem_rdata[BIT_DIRTY])) begin
                        mem_we_d    = 1'b1;
                        mem_addr_d  = o_mem_addr;
                        mem_wdata_d = i_mem_rdata | (32'h1 << BIT_ACCESSED)
                                      | ({31'h0, wr_q} << BIT_DIRTY);
                        state_d     = ST_PTE_WR;
                    end else begin
                        fire_done = 1'b1;
                        fill      = 1'b1;
                        state_d   = ST_IDLE;
                    end
                end
            end
            ST_PTE_WR: begin
                phys_d = {o_mem_wdata[31:PAGE_BITS], lin_q[PAGE_BITS-1:0]};
                if (i_mem_ack) begin
                    fire_done = 1'b1;
                    fill      = 1'b1;
                    state_d   = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Request is taken only while idle; the walker serves one access at a time
    assign o_req_ready = (state_q == ST_IDLE) && i_ce;
    // Lock spans each read and its write back, so no master slips in between
    assign o_mem_req   = (state_q == ST_PDE_RD) || (state_q == ST_PDE_WR) ||
                         (state_q == ST_PTE_RD) || (state_q == ST_PTE_WR);
    assign o_mem_lock  = o_mem_req;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer registers and captured request

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            lin_q   <= RST_WORD;
            wr_q    <= 1'b0;
            usr_q   <= 1'b0;
            desc_q  <= 1'b0;
            ip_q    <= '0;
            pde_q   <= RST_WORD;
        end else if (i_ce) begin
            state_q <= state_d;
            if (state_q == ST_IDLE && i_req_valid) begin
                lin_q  <= i_lin_addr;
                wr_q   <= i_req_write;
                usr_q  <= (i_cpl == USER_CPL);
                desc_q <= i_desc_access;
                ip_q   <= i_instr_ptr;
            end
            if (state_q == ST_PDE_RD && i_mem_ack)
                pde_q <= i_mem_rdata;
        end
    end

    // Table bus address and data come from flops
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_mem_addr  <= RST_WORD;
            o_mem_wdata <= RST_WORD;
            o_mem_we    <= 1'b0;
        end else if (i_ce && mem_load) begin
            o_mem_addr  <= mem_addr_d;
            o_mem_wdata <= mem_wdata_d;
            o_mem_we    <= mem_we_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Translation cache storage; flush wins over a fill in the same cycle

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int s = 0; s < NUM_SETS; s++) begin
                plru_q[s] <= 3'h0;
                for (int w = 0; w < TLB_WAYS; w++)
                    valid_q[s][w] <= 1'b0;
            end
        end else if (i_ce) begin
            if (flush) begin
                for (int s = 0; s < NUM_SETS; s++)
                    for (int w = 0; w < TLB_WAYS; w++)
                        valid_q[s][w] <= 1'b0;
            end else if (fill && !stale_q) begin
                valid_q[set_idx][fill_way]  <= 1'b1;
                tag_q[set_idx][fill_way]    <= tag_in;
                frame_q[set_idx][fill_way]  <= phys_d[31:PAGE_BITS];
                rights_q[set_idx][fill_way] <= min_rights(
                    {pde_q[BIT_USER], pde_q[BIT_WRITE]},
                    {pte_w[BIT_USER], pte_w[BIT_WRITE]});
                dirty_q[set_idx][fill_way]  <= wr_q || pte_w[BIT_DIRTY];
                plru_q[set_idx] <= plru_touch(plru_q[set_idx], fill_way);
            end else if (state_q == ST_LOOK && hit) begin
                plru_q[set_idx] <= plru_touch(plru_q[set_idx], hit_way);
            end
        end
    end

    // A flush during a walk marks its result stale so it is never cached
    always_ff @(posedge i_clk_sys) begin
        if (i_rst)
            stale_q <= 1'b0;
        else if (i_ce) begin
            if (flush && state_q != ST_IDLE)
                stale_q <= 1'b1;
            else if (state_q == ST_IDLE)
                stale_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result and fault outputs

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_done      <= 1'b0;
            o_fault     <= 1'b0;
            o_phys_addr <= RST_WORD;
            o_fault_vec <= VEC_PAGE_FAULT;
            o_err_code  <= 16'h0000;
            o_fault_ret <= '0;
        end else if (i_ce) begin
            o_done  <= fire_done;
            o_fault <= fire_fault;
            if (fire_done)
                o_phys_addr <= phys_d;
            if (fire_fault) begin
                // Nested faults while entering the handler still vector here
                o_fault_vec <= VEC_PAGE_FAULT;
                o_err_code  <= (16'(fault_prot) << ERR_PROT)
                             | (16'(wr_q) << ERR_WRITE)
                             | (16'(usr_q && !desc_q) << ERR_USER);
                o_fault_ret <= ip_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file over APB

    logic [31:0] fault_addr_q;
    logic [7:0]  fault_cnt_q;
    logic        apb_wr, apb_hit;

    assign apb_wr = i_psel && i_penable && i_pwrite && i_ce;
    assign flush  = (apb_wr && i_paddr == OFS_DIR_BASE) || i_task_sw;

    // Directory base: low 12 bits always read as zero
    always_ff @(posedge i_clk_sys) begin
        if (i_rst)
            dir_base_q <= RST_WORD;
        else if (i_ce) begin
            if (i_task_sw)
                dir_base_q <= {i_task_dir_base[31:PAGE_BITS], 12'h000};
            else if (apb_wr && i_paddr == OFS_DIR_BASE)
                dir_base_q <= {i_pwdata[31:PAGE_BITS], 12'h000};
        end
    end

    // Faulting linear address and a wrapping fault counter
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            fault_addr_q <= RST_WORD;
            fault_cnt_q  <= 8'h00;
        end else if (i_ce && fire_fault) begin
            fault_addr_q <= lin_q;
            fault_cnt_q  <= fault_cnt_q + 8'h01;
        end
    end

    // Zero-wait slave while the clock enable is high; unmapped addresses answer with an error
    always_comb begin
        apb_hit  = 1'b1;
        o_prdata = 32'h0000_0000;
        case (i_paddr)
            OFS_DIR_BASE:   o_prdata = dir_base_q;
            OFS_FAULT_ADDR: o_prdata = fault_addr_q;
            OFS_ERR_CODE:   o_prdata = {16'h0000, o_err_code};
            OFS_FAULT_IP:   o_prdata = o_fault_ret[31:0];
            OFS_STATUS:     o_prdata = {23'h0, fault_cnt_q, state_q != ST_IDLE};
            default:        apb_hit  = 1'b0;
        endcase
    end

    assign o_pready  = i_ce;
    assign o_pslverr = i_psel && i_penable && !apb_hit;

endmodule : ptu_top

/* testbench/page_translation_unit_tb.sv */
// Self-checking bench of the page translation unit
`timescale 1ns/1ps
module page_translation_unit_tb;
    import ptu_pkg::*;
    localparam logic [31:0] BASE = 32'h0010_0000;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rv = 0, wr = 0, dsc = 0, tsw = 0, ce = 1;
    logic prdy, perr, rr, done, flt, mreq, mwe, mlk, mack, e, wv, dv;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, lin = 0, tbase = 0, prd, phys, maddr, mwd, mrd, pde, pte, la, r;
    logic [1:0]  cpl = 0, cv, s;
    logic [47:0] ip = 0, fret;
    logic [15:0] err;
    logic [7:0]  vec;
    logic [35:0] ex;
    int          seed = 42462, miscompares = 0, n_tests = 0, cyc = 0;
    always #4 clk = ~clk;
    // Enable dropped now and then mid-walk; a frozen walker must wait for a later ack
    always @(posedge clk) ce <= !(mreq && ($random(seed) & 7) == 0);
    ptu_top ptu_top_inst (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
        .o_pready(prdy), .o_pslverr(perr), .i_req_valid(rv), .o_req_ready(rr),
        .i_lin_addr(lin), .i_req_write(wr), .i_cpl(cpl), .i_desc_access(dsc),
        .i_instr_ptr(ip), .o_done(done), .o_phys_addr(phys), .o_fault(flt),
        .o_fault_vec(vec), .o_err_code(err), .o_fault_ret(fret), .i_task_sw(tsw),
        .i_task_dir_base(tbase), .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_lock(mlk),
        .o_mem_addr(maddr), .o_mem_wdata(mwd), .i_mem_ack(mack), .i_mem_rdata(mrd));
    ptu_mem_model ptu_mem_model_inst (.i_clk_sys(clk), .i_req(mreq), .i_we(mwe),
        .i_addr(maddr), .i_wdata(mwd), .o_ack(mack), .o_rdata(mrd));
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    // APB transfer held until ready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        r = prd;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    // One translation: hand over, then wait for the answer pulse
    task automatic xlate;
        @(posedge clk);
        rv <= 1;
        do @(posedge clk); while (rr !== 1'b1);
        rv <= 0;
        do @(posedge clk); while (done !== 1'b1 && flt !== 1'b1);
    endtask : xlate
    // Expected {fault, user, write, prot, physical address}
    function automatic logic [35:0] predict(input logic [31:0] pd, pt, a, input logic w, u, d);
        logic [1:0] rt;
        rt = (pd[2:1] < pt[2:1]) ? pd[2:1] : pt[2:1];
        if (!pd[0] || !pt[0]) return {1'b1, u && !d, w, 1'b0, 32'h0000_0000};
        if (u && (!rt[1] || (w && !rt[0]))) return {1'b1, u, w, 1'b1, 32'h0000_0000};
        return {4'h0, pt[31:12], a[11:0]};
    endfunction : predict
    // A hang counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        apb(1, OFS_FAULT_ADDR, 32'hFFFF_FFFF);
        for (int a = 0; a <= 20; a += 4) begin
            apb(0, 12'(a), 32'h0000_0000);
            check(48'(r), 48'h0, "reset or read-only value");
            check(48'(e), 48'(a == 20), "slave error");
        end
        $display("Register test done");
        // Pages reuse four slots, so a missed flush shows as a stale result
        for (int i = 0; i < 60; i++) begin
            s = 2'($random(seed));
            la = {8'h00, s, 8'h00, s, 12'($random(seed))};
            pde = 32'h0020_0000 + {18'h0, s, 12'h000} + (32'($random(seed)) & 32'h0000_0007);
            pte = 32'($random(seed)) & 32'hFFFF_F007;
            wv = 1'($random(seed));
            cv = 2'($random(seed));
            dv = (($random(seed) & 3) == 0);
            if (dv) pde[0] = 1'b0;
            ptu_mem_model_inst.mem[BASE + {20'h0, la[31:22], 2'b00}] = pde;
            ptu_mem_model_inst.mem[{pde[31:12], la[21:12], 2'b00}] = pte;
            lin <= la;
            wr <= wv;
            cpl <= cv;
            dsc <= dv;
            ip <= 48'({$random(seed), $random(seed)});
            ex = predict(pde, pte, la, wv, cv == USER_CPL, dv);
            if (i[0]) begin
                tsw <= 1;
                tbase <= BASE;
                @(posedge clk);
                tsw <= 0;
            end else apb(1, OFS_DIR_BASE, BASE);
            repeat (2) begin
                xlate();
                check(48'(flt), 48'(ex[35]), "fault flag");
                if (ex[35]) check(48'(err), 48'(ex[34:32]), "error code");
                if (!ex[35]) check(48'(phys), 48'(ex[31:0]), "physical address");
                else check(fret, ip, "return pointer");
            end
            r = ptu_mem_model_inst.mem[BASE + {20'h0, la[31:22], 2'b00}];
            check(48'(r[5]), 48'(pde[0]), "directory accessed bit");
            r = ptu_mem_model_inst.mem[{pde[31:12], la[21:12], 2'b00}];
            if (!ex[35]) check(48'(r[6:5]), 48'({wv, 1'b1}), "table accessed, dirty");
            if (ex[35]) begin
                apb(0, OFS_FAULT_ADDR, 32'h0000_0000);
                check(48'(r), 48'(la), "fault address");
            end
        end
        $display("Translation test done");
        test_done();
    end
endmodule : page_translation_unit_tb

/* testbench/ptu_chk.sv */
// Concurrent checks on the ports of the page translation unit
`timescale 1ns/1ps
module ptu_chk (
    input wire logic i_clk_sys, i_rst, i_req_valid, o_req_ready, i_req_write,
    input wire logic o_done, o_fault, o_mem_req, o_mem_lock, i_desc_access,
    input wire logic [1:0] i_cpl,
    input wire logic [31:0] i_lin_addr, o_phys_addr, o_mem_addr,
    input wire logic [47:0] i_instr_ptr, o_fault_ret,
    input wire logic [15:0] o_err_code,
    input wire logic [7:0] o_fault_vec
);
    import ptu_pkg::*;
    logic [31:0] lin_q;
    logic [47:0] ip_q;
    logic        wr_q, usr_q, dsc_q;
    ////////////////////////////////////////////////////////////////////////////
    // Fields of the request in flight, kept for judging its answer
    always_ff @(posedge i_clk_sys) begin
        if (i_req_valid && o_req_ready) begin
            lin_q <= i_lin_addr;
            ip_q <= i_instr_ptr;
            wr_q <= i_req_write;
            usr_q <= (i_cpl == USER_CPL);
            dsc_q <= i_desc_access;
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    excl_pulse_a: assert property (!(o_done && o_fault)) else $error("done with fault");
    vec_fixed_a: assert property (o_fault |-> o_fault_vec == VEC_PAGE_FAULT)
        else $error("wrong vector");
    err_user_a: assert property (o_fault |-> o_err_code[ERR_USER] == (usr_q && !dsc_q))
        else $error("user flag wrong");
    err_write_a: assert property (o_fault |-> o_err_code[ERR_WRITE] == wr_q)
        else $error("write flag wrong");
    err_upper_a: assert property (o_fault |-> o_err_code[15:3] == 13'h0000)
        else $error("error code upper bits set");
    super_prot_a: assert property (o_fault && !usr_q |-> !o_err_code[ERR_PROT])
        else $error("supervisor rights fault");
    ret_ptr_a: assert property (o_fault |-> o_fault_ret == ip_q) else $error("bad return");
    page_off_a: assert property (o_done |-> o_phys_addr[11:0] == lin_q[11:0])
        else $error("offset not passed");
    dir_index_a: assert property ($rose(o_mem_req) |-> o_mem_addr[11:0] == {lin_q[31:22], 2'b00})
        else $error("directory index wrong");
    lock_walk_a: assert property (o_mem_req |-> o_mem_lock && !o_req_ready)
        else $error("walk not locked");
    hit_time_a: assert property (i_req_valid && o_req_ready |=> ##1 (o_done || o_fault || o_mem_req))
        else $error("lookup too slow");
    cover property (o_done);
    cover property (o_fault && o_err_code[ERR_PROT]);
    cover property (o_fault && !o_err_code[ERR_PROT]);
endmodule : ptu_chk
bind ptu_top ptu_chk ptu_chk_inst (.*);

/* testbench/ptu_mem_model.sv */
// Behavioural memory holding the page tables on the walk bus
`timescale 1ns/1ps
module ptu_mem_model (
    input  wire logic        i_clk_sys, // Clock
    input  wire logic        i_req,     // Bus request
    input  wire logic        i_we,      // Write
    input  wire logic [31:0] i_addr,    // Address
    input  wire logic [31:0] i_wdata,   // Write data
    output logic             o_ack = 0, // Cycle done
    output logic      [31:0] o_rdata = 0 // Read data
);
    logic [31:0] mem [logic [31:0]];
    logic [1:0]  wait_q = 2'h2;
    int          seed = 42462;
    ////////////////////////////////////////////////////////////////////////////
    // Two or three idle cycles per bus cycle, so the walker cannot assume
    // a latency; a released data bus shows the inverse of its last value.
    always @(posedge i_clk_sys) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (!i_req) begin
            wait_q <= 2'h2;
        end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else begin
            o_ack <= 1'b1;
            wait_q <= 2'h2 + 2'($random(seed) & 1);
            if (i_we) mem[i_addr] = i_wdata;
            else o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 32'h0000_0000;
        end
    end
endmodule : ptu_mem_model
